//--- design/ndg_consts.svh
`ifndef NDG_CONSTS_SVH
`define NDG_CONSTS_SVH

// register byte offsets
`define NDG_OFF_CMD     8'h00
`define NDG_OFF_STATUS  8'h04
`define NDG_OFF_COUNTER 8'h08
`define NDG_OFF_CNTCFG  8'h0C
`define NDG_OFF_PWD0    8'h10
`define NDG_OFF_PWD3    8'h1C
`define NDG_OFF_COND    8'h20

// command word fields
`define NDG_CMD_OP_MSB  3
`define NDG_CMD_WITHPW  4
`define NDG_CMD_ARG_LSB 8
`define NDG_CMD_ARG_MSB 15

// status words answered to the reader
`define NDG_SW_OK      16'h9000
`define NDG_SW_PROT    16'h6300
`define NDG_SW_FORBID  16'h6984
`define NDG_SW_NOFILE  16'h6A82
`define NDG_SW_DENIED  16'h6982
`define NDG_SW_LOCKED  16'h6985

// counter configuration byte
`define NDG_CFG_LOCK   7
`define NDG_CFG_EN     1
`define NDG_CFG_SEL    0
`define NDG_CFG_MASK   8'h83
`define NDG_CFG_RESET  8'h00

// access condition bytes
`define NDG_COND_OPEN  8'h00
`define NDG_COND_SHUT  8'hFF

`define NDG_FAIL_LIMIT 2'h3
`define NDG_PW_RESET   128'h0
`define NDG_CNT_RESET  20'h0_0000

`endif

//--- design/ndg_guard.sv
// Functional notes
// (RQ1) Two 128-bit passwords: one for reading, one for writing and mode changes.
// (RQ2) Reader presents read password before reading a read-protected message file.
// (RQ3) Reader presents write password before writing or changing protection modes.
// (RQ4) Verify with capability, system or no file selected answers an error.
// (RQ5) Query 0x0001 without password reports read mode: 9000, 6300 or 6984.
// (RQ6) Query 0x0002 without password reports write mode with the same words.
// (RQ7) Both protection modes start unprotected.
// (RQ8) Forbidden mode is permanent and never grants access.
// (RQ9) Read access condition byte always reads 0x00.
// (RQ10) Write condition byte reads 0x00 unprotected, 0xFF otherwise.
// (RQ11) Protected access granted from first correct password until revoked.
// (RQ12) Field loss, deselect, app, capability or system select, wrong password revoke.
// (RQ13) Three failures lock a password until standby, activation, app and file select.
// (RQ14) A 20-bit counter counts either read or write events.
// (RQ15) Counter updates are tearing-safe.
// (RQ16) Counter value is readable by anyone.
// (RQ17) Counter increments once on first configured event after app select.
// (RQ18) Disabling clears the counter; nothing else but increments changes it.
// (RQ19) Configuration byte enables, selects event type and can lock itself.
// (RQ20) Config bits: b7 lock, b1 enable, b0 event (0 read, 1 write).
// (RQ21) Once the lock bit is set, later changes to the byte are rejected.
// (RQ22) Each password keeps a failure tally cleared on success or recovery.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "ndg_consts.svh"
module ndg_guard
	import ndg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	ndg_pw_if rd_if ();
	ndg_pw_if wr_if ();

	ndg_pw_check u_rd_check
	(
		.clk   (clk),
		.reset (reset),
		.pw    (rd_if)
	);

	ndg_pw_check u_wr_check
	(
		.clk   (clk),
		.reset (reset),
		.pw    (wr_if)
	);

	logic [31:0] pwd [4];
	logic [15:0] sw;
	logic [15:0] next_sw;
	ndg_mode_t   rd_mode;
	ndg_mode_t   wr_mode;
	ndg_file_t   file_sel;
	ndg_rec_t    rec;
	logic [7:0]  cnt_cfg;
	logic [19:0] slot0;
	logic [19:0] slot1;
	logic        act;
	logic        pend;
	logic        armed;

	logic        mapped;
	logic        cmd_go;
	ndg_op_t     op;
	logic        with_pw;
	logic [7:0]  arg;
	logic        in_ndef;
	logic        rd_allow;
	logic        wr_allow;
	logic        bump;
	logic        cfg_take;
	logic        mode_take;
	logic [19:0] cnt_val;
	logic [7:0]  rd_cond;
	logic [7:0]  wr_cond;
	logic        rec_done;

	assign mapped = (paddr == `NDG_OFF_CMD) || (paddr == `NDG_OFF_STATUS)
		|| (paddr == `NDG_OFF_COUNTER) || (paddr == `NDG_OFF_CNTCFG)
		|| (paddr == `NDG_OFF_COND)
		|| ((paddr >= `NDG_OFF_PWD0) && (paddr <= `NDG_OFF_PWD3) && (paddr[1:0] == 2'h0));
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	assign cmd_go  = psel && penable && pwrite && (paddr == `NDG_OFF_CMD);
	assign op      = ndg_op_t'(pwdata[`NDG_CMD_OP_MSB:0]);
	assign with_pw = pwdata[`NDG_CMD_WITHPW];
	assign arg     = pwdata[`NDG_CMD_ARG_MSB:`NDG_CMD_ARG_LSB];
	assign in_ndef = (file_sel == FILE_NDEF);

	// forbidden never grants, whatever the checker holds
	assign rd_allow = (rd_mode == MODE_UNPROT) || ((rd_mode == MODE_PROT) && rd_if.granted); // RQ8
	assign wr_allow = (wr_mode == MODE_UNPROT) || ((wr_mode == MODE_PROT) && wr_if.granted); // RQ8

	assign cnt_val = act ? slot1 : slot0;
	assign rd_cond = `NDG_COND_OPEN; // RQ9
	assign wr_cond = (wr_mode == MODE_UNPROT) ? `NDG_COND_OPEN : `NDG_COND_SHUT; // RQ10

	assign rd_if.cand    = {pwd[3], pwd[2], pwd[1], pwd[0]};
	assign wr_if.cand    = {pwd[3], pwd[2], pwd[1], pwd[0]};
	assign rd_if.new_pw  = {pwd[3], pwd[2], pwd[1], pwd[0]};
	assign wr_if.new_pw  = {pwd[3], pwd[2], pwd[1], pwd[0]};
	assign rd_if.present = cmd_go && (op == OP_VERIFY_RD) && with_pw && in_ndef
		&& (rd_mode != MODE_FORBID); // RQ4
	assign wr_if.present = cmd_go && (op == OP_VERIFY_WR) && with_pw && in_ndef
		&& (wr_mode != MODE_FORBID); // RQ4
	// password change needs write access, like a mode change
	assign rd_if.load = cmd_go && (op == OP_CHANGE_PW) && in_ndef && wr_allow && !arg[0]; // RQ3
	assign wr_if.load = cmd_go && (op == OP_CHANGE_PW) && in_ndef && wr_allow && arg[0]; // RQ3
	assign rd_if.revoke = cmd_go && ((op == OP_FIELD_OFF) || (op == OP_DESELECT)
		|| (op == OP_SEL_APP) || (op == OP_SEL_CC) || (op == OP_SEL_SYS)); // RQ12
	assign wr_if.revoke = rd_if.revoke; // RQ12
	assign rec_done     = cmd_go && (op == OP_SEL_NDEF) && (rec == REC_APP);
	assign rd_if.recover = rec_done; // RQ13
	assign wr_if.recover = rec_done; // RQ13

	assign mode_take = cmd_go && ((op == OP_SET_RD) || (op == OP_SET_WR)) && in_ndef
		&& wr_allow && (arg[1:0] != 2'b11)
		&& !((op == OP_SET_RD) ? (rd_mode == MODE_FORBID) : (wr_mode == MODE_FORBID)); // RQ3
	assign cfg_take  = cmd_go && (op == OP_WRITE_CFG) && (file_sel == FILE_SYS)
		&& !cnt_cfg[`NDG_CFG_LOCK]; // RQ21
	assign bump = cmd_go && armed && cnt_cfg[`NDG_CFG_EN] && in_ndef && !pend
		&& (((op == OP_READ_EVT) && !cnt_cfg[`NDG_CFG_SEL] && rd_allow)
		|| ((op == OP_WRITE_EVT) && cnt_cfg[`NDG_CFG_SEL] && wr_allow)); // RQ17

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < 4; i++)
				pwd[i] <= 32'h0000_0000;
		end
		else if (psel && penable && pwrite && (paddr >= `NDG_OFF_PWD0)
			&& (paddr <= `NDG_OFF_PWD3) && (paddr[1:0] == 2'h0))
			pwd[paddr[3:2]] <= pwdata;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			case (paddr)
				`NDG_OFF_STATUS:  prdata <= {8'h00, rd_if.locked, wr_if.locked,
					wr_allow, rd_allow, wr_mode, rd_mode, sw};
				`NDG_OFF_COUNTER: prdata <= {12'h000, cnt_val}; // RQ16
				`NDG_OFF_CNTCFG:  prdata <= {24'h00_0000, cnt_cfg};
				`NDG_OFF_COND:    prdata <= {16'h0000, wr_cond, rd_cond};
				default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_comb
	begin
		next_sw = sw;
		if (cmd_go)
		begin
			case (op)
				OP_VERIFY_RD, OP_VERIFY_WR:
				begin
					if (!in_ndef)
						next_sw = `NDG_SW_NOFILE; // RQ4
					else if (((op == OP_VERIFY_RD) ? rd_mode : wr_mode) == MODE_FORBID)
						next_sw = `NDG_SW_FORBID; // RQ8
					else if (!with_pw)
						next_sw = ((((op == OP_VERIFY_RD) ? rd_mode : wr_mode) == MODE_UNPROT)
							? `NDG_SW_OK : `NDG_SW_PROT); // RQ5 RQ6
					else
						next_sw = (rd_if.ok || wr_if.ok) ? `NDG_SW_OK : `NDG_SW_PROT;
				end
				OP_READ_EVT:
					next_sw = !in_ndef ? `NDG_SW_NOFILE : (rd_allow ? `NDG_SW_OK : `NDG_SW_DENIED);
				OP_WRITE_EVT:
					next_sw = !in_ndef ? `NDG_SW_NOFILE : (wr_allow ? `NDG_SW_OK : `NDG_SW_DENIED);
				OP_SET_RD, OP_SET_WR, OP_CHANGE_PW:
					next_sw = (mode_take || rd_if.load || wr_if.load) ? `NDG_SW_OK
						: `NDG_SW_DENIED;
				OP_WRITE_CFG:
					next_sw = (file_sel != FILE_SYS) ? `NDG_SW_NOFILE
						: (cfg_take ? `NDG_SW_OK : `NDG_SW_LOCKED); // RQ21
				default:
					next_sw = `NDG_SW_OK;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			sw <= `NDG_SW_OK;
		else
			sw <= next_sw;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rd_mode <= MODE_UNPROT; // RQ7
			wr_mode <= MODE_UNPROT; // RQ7
		end
		else if (mode_take && (op == OP_SET_RD))
			rd_mode <= ndg_mode_t'(arg[1:0]); // RQ3
		else if (mode_take)
			wr_mode <= ndg_mode_t'(arg[1:0]); // RQ3
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			file_sel <= FILE_NONE;
		else if (cmd_go)
		begin
			case (op)
				OP_FIELD_OFF, OP_DESELECT, OP_SEL_APP: file_sel <= FILE_NONE;
				OP_SEL_CC:   file_sel <= FILE_CC;
				OP_SEL_SYS:  file_sel <= FILE_SYS;
				OP_SEL_NDEF: file_sel <= FILE_NDEF;
				default:     file_sel <= file_sel;
			endcase
		end
	end

	// standby, activation, app select, then message-file select
	always_ff @(posedge clk)
	begin
		if (reset)
			rec <= REC_IDLE;
		else if (cmd_go)
		begin
			case (rec)
				REC_IDLE: if ((op == OP_FIELD_OFF) || (op == OP_DESELECT)) rec <= REC_STBY;
				REC_STBY: if (op == OP_ACTIVATE) rec <= REC_ACT; // RQ13
				REC_ACT:  if (op == OP_SEL_APP) rec <= REC_APP; // RQ13
				REC_APP:  if (op == OP_SEL_NDEF) rec <= REC_IDLE; // RQ13
				default:  rec <= REC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			cnt_cfg <= `NDG_CFG_RESET;
		else if (cfg_take)
			cnt_cfg <= arg & `NDG_CFG_MASK; // RQ19 RQ20
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			armed <= 1'b0;
		else if (cmd_go && (op == OP_SEL_APP))
			armed <= 1'b1; // RQ17
		else if (bump)
			armed <= 1'b0; // RQ17
	end

	// new value lands in the idle slot, then the pointer flips: a torn
	// update leaves the old slot selected
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			slot0 <= `NDG_CNT_RESET;
			slot1 <= `NDG_CNT_RESET;
			act   <= 1'b0;
			pend  <= 1'b0;
		end
		else if (cfg_take && !arg[`NDG_CFG_EN])
		begin
			slot0 <= `NDG_CNT_RESET; // RQ18
			slot1 <= `NDG_CNT_RESET; // RQ18
			pend  <= 1'b0;
		end
		else if (bump)
		begin
			if (act)
				slot0 <= cnt_val + 20'h0_0001; // RQ14 RQ15
			else
				slot1 <= cnt_val + 20'h0_0001; // RQ14 RQ15
			pend <= 1'b1;
		end
		else if (pend)
		begin
			act  <= ~act; // RQ15
			pend <= 1'b0;
		end
	end

	rd_cond_zero_a: assert property (@(posedge clk) disable iff (reset) // RQ9
		rd_cond == 8'h00)
		else $error("read condition byte not zero");

	wr_cond_map_a: assert property (@(posedge clk) disable iff (reset) // RQ10
		wr_cond == ((wr_mode == MODE_UNPROT) ? 8'h00 : 8'hFF))
		else $error("write condition byte wrong for mode");

	forbid_sticky_a: assert property (@(posedge clk) disable iff (reset) // RQ8
		(rd_mode == MODE_FORBID) |=> (rd_mode == MODE_FORBID) && !rd_allow)
		else $error("forbidden read mode left");

	verify_nofile_a: assert property (@(posedge clk) disable iff (reset) // RQ4
		cmd_go && ((op == OP_VERIFY_RD) || (op == OP_VERIFY_WR)) && !in_ndef
		|=> sw == 16'h6A82)
		else $error("verify outside message file not refused");

	query_rd_a: assert property (@(posedge clk) disable iff (reset) // RQ5
		cmd_go && (op == OP_VERIFY_RD) && !with_pw && in_ndef && (rd_mode == MODE_PROT)
		|=> sw == 16'h6300)
		else $error("protected read query answered wrong");

	revoke_all_a: assert property (@(posedge clk) disable iff (reset) // RQ12
		rd_if.revoke |=> !rd_if.granted && !wr_if.granted)
		else $error("access survived a revoking event");

	cnt_stable_a: assert property (@(posedge clk) disable iff (reset) // RQ18
		!bump && !cfg_take && !pend |=> cnt_val == $past(cnt_val))
		else $error("counter moved without cause");

	cnt_once_a: assert property (@(posedge clk) disable iff (reset) // RQ17
		bump |=> !armed ##1 (cnt_val == $past(cnt_val, 2) + 20'h0_0001))
		else $error("counter increment wrong");

	cfg_lock_a: assert property (@(posedge clk) disable iff (reset) // RQ21
		cnt_cfg[7] |=> cnt_cfg == $past(cnt_cfg))
		else $error("locked configuration changed");
endmodule

//--- design/ndg_pkg.sv
package ndg_pkg;

	typedef enum logic [1:0]
	{
		MODE_UNPROT = 2'b00,
		MODE_PROT   = 2'b01,
		MODE_FORBID = 2'b10
	} ndg_mode_t;

	typedef enum logic [1:0]
	{
		FILE_NONE = 2'b00,
		FILE_CC   = 2'b01,
		FILE_SYS  = 2'b10,
		FILE_NDEF = 2'b11
	} ndg_file_t;

	typedef enum logic [1:0]
	{
		REC_IDLE = 2'b00,
		REC_STBY = 2'b01,
		REC_ACT  = 2'b10,
		REC_APP  = 2'b11
	} ndg_rec_t;

	typedef enum logic [3:0]
	{
		OP_NOP       = 4'b0000,
		OP_FIELD_OFF = 4'b0001,
		OP_DESELECT  = 4'b0010,
		OP_ACTIVATE  = 4'b0011,
		OP_SEL_APP   = 4'b0100,
		OP_SEL_CC    = 4'b0101,
		OP_SEL_SYS   = 4'b0110,
		OP_SEL_NDEF  = 4'b0111,
		OP_VERIFY_RD = 4'b1000,
		OP_VERIFY_WR = 4'b1001,
		OP_READ_EVT  = 4'b1010,
		OP_WRITE_EVT = 4'b1011,
		OP_SET_RD    = 4'b1100,
		OP_SET_WR    = 4'b1101,
		OP_WRITE_CFG = 4'b1110,
		OP_CHANGE_PW = 4'b1111
	} ndg_op_t;

endpackage

//--- design/ndg_pw_check.sv
`timescale 1ns/1ns
`include "ndg_consts.svh"
module ndg_pw_check
	import ndg_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	ndg_pw_if.chk    pw
);
	logic [127:0] secret;
	logic [1:0]   tally;

	assign pw.locked = (tally == `NDG_FAIL_LIMIT); // RQ13
	assign pw.ok     = pw.present && !pw.locked && (pw.cand == secret); // RQ13
	assign pw.fail   = pw.present && !pw.ok;

	always_ff @(posedge clk)
	begin
		if (reset)
			secret <= `NDG_PW_RESET;
		else if (pw.load)
			secret <= pw.new_pw; // RQ1
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			tally <= 2'h0;
		else if (pw.recover || pw.ok)
			tally <= 2'h0; // RQ22
		else if (pw.fail && !pw.locked)
			tally <= tally + 2'h1; // RQ22
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			pw.granted <= 1'b0;
		else if (pw.fail || pw.revoke)
			pw.granted <= 1'b0; // RQ12
		else if (pw.ok)
			pw.granted <= 1'b1; // RQ11
	end

	lockout_refuse_a: assert property (@(posedge clk) disable iff (reset) // RQ13
		pw.locked && pw.present |-> !pw.ok ##1 !pw.granted)
		else $error("locked password was accepted");

	tally_count_a: assert property (@(posedge clk) disable iff (reset) // RQ22
		pw.fail && !pw.locked && !pw.recover |=> tally == $past(tally) + 2'h1)
		else $error("failure tally did not advance");
endmodule

//--- design/ndg_pw_if.sv
`timescale 1ns/1ns
interface ndg_pw_if;
	logic         load;
	logic [127:0] new_pw;
	logic         present;
	logic [127:0] cand;
	logic         revoke;
	logic         recover;
	logic         ok;
	logic         fail;
	logic         granted;
	logic         locked;

	modport chk (input load, new_pw, present, cand, revoke, recover,
		output ok, fail, granted, locked);
	modport gd (output load, new_pw, present, cand, revoke, recover,
		input ok, fail, granted, locked);
endinterface

//--- verif/ndef_access_guard_and_event_counter_tb_top.sv
`timescale 1ns/1ns
`include "ndg_consts.svh"
module ndef_access_guard_and_event_counter_tb_top
	import ndg_pkg::*;
	;
	logic        clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hung;
	logic [31:0] seed;
	int          failures;
	int          num_checks;
	int          k;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	logic [32:0] mon_e;
	logic [32:0] mon_m;
	logic [127:0] rpw;
	logic [127:0] wpw;
	ndg_op_t     evs[6];

	ndg_guard DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	ndg_host_model host (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .hung(hung));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
		exp_q.push_back({e, d & m});
		msk_q.push_back({1'b1, m});
		host.xfer(1'b0, a, 32'h00000000);
	endtask

	task cmd(input ndg_op_t op, input logic wp, input logic [7:0] arg);
		host.xfer(1'b1, `NDG_OFF_CMD, {16'h0000, arg, 3'b000, wp, op});
	endtask

	task sw(input logic [15:0] w);
		rd(`NDG_OFF_STATUS, {16'h0000, w}, 32'h0000FFFF, 1'b0);
	endtask

	task vfy(input ndg_op_t op, input logic [127:0] p);
		for (int i = 0; i < 4; i++)
			host.xfer(1'b1, 8'(`NDG_OFF_PWD0 + 4 * i), p[32 * i +: 32]);
		cmd(op, 1'b1, 8'h00);
	endtask

	task cnt(input logic [19:0] v);
		// counter commit lands two cycles after the command
		@(posedge clk);
		rd(`NDG_OFF_COUNTER, {12'h000, v}, 32'h000FFFFF, 1'b0);
	endtask

	// results are compared in arrival order
	always @(posedge clk)
		if (psel && penable && pready && !pwrite)
		begin
			if (exp_q.size() == 0)
				check(33'h000000000, 33'h000000001);
			else
			begin
				mon_e = exp_q.pop_front();
				mon_m = msk_q.pop_front();
				check({pslverr, prdata} & mon_m, mon_e);
			end
		end

	always @(posedge clk)
		if (hung === 1'b1)
		begin
			failures++;
			conclude();
		end

	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude();
	end

	initial
	begin
		seed = 32'hC2402AFB;
		failures = 0;
		num_checks = 0;
		reset = 1'b1;
		rpw = {$random(seed), $random(seed), $random(seed), $random(seed)};
		wpw = {$random(seed), $random(seed), $random(seed), $random(seed)};
		evs = '{OP_FIELD_OFF, OP_DESELECT, OP_SEL_APP, OP_SEL_CC, OP_SEL_SYS, OP_VERIFY_RD};
		repeat (2) @(posedge clk);
		reset <= 1'b0;

		sw(`NDG_SW_OK);
		rd(`NDG_OFF_STATUS, 32'h00000000, 32'h000F0000, 1'b0);
		rd(`NDG_OFF_COND, 32'h00000000, 32'h0000FFFF, 1'b0);
		rd(`NDG_OFF_COUNTER, 32'h00000000, 32'hFFFFFFFF, 1'b0);
		rd(`NDG_OFF_CNTCFG, 32'h00000000, 32'h000000FF, 1'b0);
		rd(8'h40, 32'h00000000, 32'hFFFFFFFF, 1'b1);
		cmd(OP_VERIFY_RD, 1'b0, 8'h00);
		sw(`NDG_SW_NOFILE);
		cmd(OP_ACTIVATE, 1'b0, 8'h00);
		for (int i = 2; i < 5; i++)
		begin
			cmd(evs[i], 1'b0, 8'h00);
			cmd(OP_VERIFY_RD, 1'b0, 8'h00);
			sw(`NDG_SW_NOFILE);
		end
		$display("test reset_and_nofile done");

		cmd(OP_SEL_APP, 1'b0, 8'h00);
		cmd(OP_SEL_SYS, 1'b0, 8'h00);
		cmd(OP_WRITE_CFG, 1'b0, 8'h02);
		rd(`NDG_OFF_CNTCFG, 32'h00000002, 32'h000000FF, 1'b0);
		cmd(OP_SEL_NDEF, 1'b0, 8'h00);
		cmd(OP_READ_EVT, 1'b0, 8'h00);
		cmd(OP_READ_EVT, 1'b0, 8'h00);
		cmd(OP_WRITE_EVT, 1'b0, 8'h00);
		cnt(20'h00001);
		cmd(OP_SEL_APP, 1'b0, 8'h00);
		cmd(OP_SEL_NDEF, 1'b0, 8'h00);
		cmd(OP_READ_EVT, 1'b0, 8'h00);
		cnt(20'h00002);
		cmd(OP_SEL_SYS, 1'b0, 8'h00);
		cmd(OP_WRITE_CFG, 1'b0, 8'h03);
		cmd(OP_SEL_APP, 1'b0, 8'h00);
		cmd(OP_SEL_NDEF, 1'b0, 8'h00);
		cmd(OP_READ_EVT, 1'b0, 8'h00);
		cmd(OP_WRITE_EVT, 1'b0, 8'h00);
		cnt(20'h00003);
		cmd(OP_SEL_SYS, 1'b0, 8'h00);
		cmd(OP_WRITE_CFG, 1'b0, 8'h00);
		cnt(20'h00000);
		cmd(OP_WRITE_CFG, 1'b0, 8'h82);
		cmd(OP_WRITE_CFG, 1'b0, 8'h00);
		sw(`NDG_SW_LOCKED);
		rd(`NDG_OFF_CNTCFG, 32'h00000082, 32'h000000FF, 1'b0);
		$display("test event_counter done");

		cmd(OP_SEL_APP, 1'b0, 8'h00);
		cmd(OP_SEL_NDEF, 1'b0, 8'h00);
		cmd(OP_VERIFY_RD, 1'b0, 8'h00);
		sw(`NDG_SW_OK);
		cmd(OP_VERIFY_WR, 1'b0, 8'h00);
		sw(`NDG_SW_OK);
		vfy(OP_CHANGE_PW, rpw);
		sw(`NDG_SW_OK);
		for (int i = 0; i < 4; i++)
			host.xfer(1'b1, 8'(`NDG_OFF_PWD0 + 4 * i), wpw[32 * i +: 32]);
		cmd(OP_CHANGE_PW, 1'b0, 8'h01);
		cmd(OP_SET_RD, 1'b0, 8'h01);
		cmd(OP_SET_WR, 1'b0, 8'h01);
		sw(`NDG_SW_OK);
		cmd(OP_VERIFY_RD, 1'b0, 8'h00);
		sw(`NDG_SW_PROT);
		cmd(OP_VERIFY_WR, 1'b0, 8'h00);
		sw(`NDG_SW_PROT);
		rd(`NDG_OFF_COND, 32'h0000FF00, 32'h0000FFFF, 1'b0);
		rd(`NDG_OFF_STATUS, 32'h00050000, 32'h000F0000, 1'b0);
		$display("test protect done");

		for (int i = 0; i < 6; i++)
		begin
			cmd(OP_ACTIVATE, 1'b0, 8'h00);
			cmd(OP_SEL_APP, 1'b0, 8'h00);
			cmd(OP_SEL_NDEF, 1'b0, 8'h00);
			vfy(OP_VERIFY_RD, rpw);
			rd(`NDG_OFF_STATUS, 32'h00109000, 32'h0010FFFF, 1'b0);
			if (i == 5)
				vfy(OP_VERIFY_RD, ~rpw);
			else
				cmd(evs[i], 1'b0, 8'h00);
			rd(`NDG_OFF_STATUS, 32'h00000000, 32'h00100000, 1'b0);
		end
		$display("test revoke done");

		cmd(OP_ACTIVATE, 1'b0, 8'h00);
		cmd(OP_SEL_APP, 1'b0, 8'h00);
		cmd(OP_SEL_NDEF, 1'b0, 8'h00);
		// clear the tally left by the last wrong try
		vfy(OP_VERIFY_RD, rpw);
		sw(`NDG_SW_OK);
		for (int i = 0; i < 2; i++)
		begin
			vfy(OP_VERIFY_RD, rpw ^ 128'h1);
			vfy(OP_VERIFY_RD, rpw ^ 128'h2);
			vfy(OP_VERIFY_RD, rpw);
			sw(`NDG_SW_OK);
		end
		for (int i = 0; i < 3; i++)
		begin
			vfy(OP_VERIFY_RD, ~rpw);
			sw(`NDG_SW_PROT);
		end
		vfy(OP_VERIFY_RD, rpw);
		rd(`NDG_OFF_STATUS, 32'h00806300, 32'h0090FFFF, 1'b0);
		cmd(OP_DESELECT, 1'b0, 8'h00);
		cmd(OP_ACTIVATE, 1'b0, 8'h00);
		cmd(OP_SEL_APP, 1'b0, 8'h00);
		cmd(OP_SEL_NDEF, 1'b0, 8'h00);
		vfy(OP_VERIFY_RD, rpw);
		rd(`NDG_OFF_STATUS, 32'h00109000, 32'h0090FFFF, 1'b0);
		$display("test lockout done");

		vfy(OP_VERIFY_WR, wpw);
		cmd(OP_SET_RD, 1'b0, 8'h02);
		cmd(OP_SET_WR, 1'b0, 8'h02);
		cmd(OP_VERIFY_RD, 1'b0, 8'h00);
		sw(`NDG_SW_FORBID);
		cmd(OP_VERIFY_WR, 1'b0, 8'h00);
		sw(`NDG_SW_FORBID);
		cmd(OP_SET_RD, 1'b0, 8'h00);
		vfy(OP_VERIFY_RD, rpw);
		vfy(OP_VERIFY_WR, wpw);
		rd(`NDG_OFF_STATUS, 32'h000A0000, 32'h003F0000, 1'b0);
		rd(`NDG_OFF_COND, 32'h0000FF00, 32'h0000FFFF, 1'b0);
		$display("test forbid done");

		for (k = 0; k < 50 && exp_q.size() > 0; k++)
			@(posedge clk);
		if (exp_q.size() != 0)
			failures++;
		conclude();
	end
endmodule

//--- verif/ndg_host_model.sv
`timescale 1ns/1ns
module ndg_host_model
(
	input  wire logic        clk,
	input  wire logic        reset,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic        pready,
	output logic             hung
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		hung = 1'b0;
	end

	// one apb transfer, request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 100);
		if (n >= 100)
			hung <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines do not keep the last value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
